// >>> pkg/buck_cfg.svh
// Purpose: Constants for the buck charger switching and protection block
// Assumes: 250 MHz mclk_i, 4 ns period
// Notes:   Times in their own unit, cycle counts derived from them
`ifndef BUCK_CFG_SVH
`define BUCK_CFG_SVH

`define CLK_MHZ           250
`define NS_PER_CLK        4
// Register offsets
`define REG_OPTION        4'h0
`define REG_VTARGET       4'h1
`define REG_ITARGET       4'h2
`define REG_PERIOD        4'h3
`define REG_STATUS        4'h4
`define REG_SHORTCNT      4'h5
// Option word bit positions
`define OPT_INHIBIT       0
`define OPT_INOC_EN       1
`define OPT_LS_HI_TH      7
`define OPT_HS_SHORT_EN   8
`define OPT_FADJ_EN       9
`define OPT_FADJ_UP       10
// Reset values
`define OPTION_RST        16'h0102
`define PERIOD_RST        16'h014d
`define RAMP_OFFSET_RST   16'h000c
// Timing
`define DEAD_NS           20
`define DEAD_CYC          ((`DEAD_NS + `NS_PER_CLK - 1) / `NS_PER_CLK)
`define INOC_BLANK_US     4200
`define BATOV_QUAL_US     30000
`define SHORT_RESET_US    1000
`define SHORT_RESUME_US   4500
`define SS_STEP_US        240
`define US_TO_CYC(u)      ((u) * `CLK_MHZ)
// Soft-start current codes, 64 mA per lsb
`define SS_INIT_CODE      16'h0002
`define SS_STEP_CODE      16'h0001
// Peak over-current tiers, charge-current code limits
`define OCP_TIER1_MAX     16'h0040
`define OCP_TIER2_MAX     16'h0060
`define FADJ_PCT          18
`define PCT_SCALE         100
`define BSHORT_CAP_CODE   16'h0008
`define SHORT_LIMIT       3'h7

`endif

// >>> pkg/buck_pkg.sv
// Purpose: Types for the buck charger switching and protection block
// Assumes: Constants live in buck_cfg.svh
// Notes:   Status word layout shared with the testbench
package buck_pkg;

  typedef enum logic [1:0] {
    OCP_6A,
    OCP_9A,
    OCP_12A
  } ocp_tier_type;

  typedef struct packed {
    logic hs_short;
    logic ls_short;
    logic peak_oc;
    logic under_current;
    logic ramp_above;
    logic boot_low;
    logic battery_overvoltage;
    logic battery_shorted_floor;
    logic thermal_hi;
    logic thermal_lo;
    logic input_overcurrent_trip;
    logic avg_below_low;
    logic avg_above_high;
    logic adapter_detect_low;
    logic supply_undervoltage_lockout;
  } sense_type;

  typedef struct packed {
    logic [4:0]   rsvd;
    ocp_tier_type tier;
    logic         nonsync;
    logic         short_latched;
    logic         inoc_latched;
    logic         batov_active;
    logic         batov_disabled;
    logic         bat_short;
    logic         thermal_off;
    logic         charging;
    logic         high_side;
  } status_type;

endpackage

// >>> rtl/buck_ctrl.sv
// Purpose: Gate pattern, conduction mode and protection sequencing of a buck charger
// Assumes: Comparators arrive as levels; host option bits come over a plain register port
// Notes:   Ramp is digital, a count across the switching period
//
// Operation
// - Cycle start restarts ramp; high side while above
// - Ramp crosses: high off, low on; end low
// - Dead time; both gates never on together
// - Under-current turns low side off rest-of-cycle
// - Low average or low battery: non-synchronous
// - Average above upper limit resumes synchronous
// - Input over-current past blanking latches switches off
// - Option bit enables input over-current latch
// - Peak over-current ends high side this cycle
// - Peak threshold tier chosen from current code
// - Over-voltage inhibits both gate turn-ons
// - Over-voltage over 30 ms disables charging
// - Discharge sink on only during over-voltage
// - Zero voltage target never flags over-voltage
// - Shorted battery: reset 1 ms, resume later
// - Shorted battery: reduced cap, low off
// - Thermal stop with hysteresis, soft-start resume
// - Option bits shift frequency down or up
// - Seventh short event latches off, battery on
// - Short latch clears on lockout or adapter
// - Option bit picks low-side short threshold
// - Option bit enables high-side short detection
// - Soft-start ramps current target in steps
// - Bootstrap low triggers low-side refresh pulse
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "buck_cfg.svh"

module buck_ctrl #(
  parameter int INOC_BLANK_CYC  = `US_TO_CYC(`INOC_BLANK_US),
  parameter int BATOV_QUAL_CYC  = `US_TO_CYC(`BATOV_QUAL_US),
  parameter int SHORT_RST_CYC   = `US_TO_CYC(`SHORT_RESET_US),
  parameter int SHORT_RES_CYC   = `US_TO_CYC(`SHORT_RESUME_US),
  parameter int SS_STEP_CYC     = `US_TO_CYC(`SS_STEP_US),
  parameter int TW              = 24
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [15:0]       reg_rdata_o,
  input  wire buck_pkg::sense_type sense_i,
  output logic                   high_side_switch_o,
  output logic                   low_side_switch_o,
  output logic                   adapter_switch_o,
  output logic                   reverse_block_switch_o,
  output logic                   battery_switch_o,
  output logic                   discharge_sink_o,
  output logic      [15:0]       ramp_o,
  output logic      [15:0]       current_target_o,
  output buck_pkg::ocp_tier_type ocp_tier_o,
  output logic                   ls_short_high_th_o,
  output logic                   hs_short_en_o
);

  // ==========================================================
  // Helpers
  function automatic logic done(input logic [TW-1:0] c, input int lim);
    done = (c >= TW'(lim));
  endfunction

  function automatic logic [TW-1:0] bump(input logic [TW-1:0] c, input logic run);
    bump = run ? c + TW'(1) : '0;
  endfunction

  // ==========================================================
  // Input synchronisers
  buck_pkg::sense_type s1_q;
  buck_pkg::sense_type s_q;

  always_ff @(posedge mclk_i) begin
    s1_q <= sense_i;
    s_q  <= s1_q;
  end

  // ==========================================================
  // Register port
  logic [15:0] option_q;
  logic [15:0] vtarget_q;
  logic [15:0] itarget_q;
  logic [15:0] period_q;
  logic [2:0]  short_cnt_q;
  buck_pkg::status_type st;

  wire wr_opt = reg_wr_i && reg_addr_i == `REG_OPTION;
  wire wr_vt  = reg_wr_i && reg_addr_i == `REG_VTARGET;
  wire wr_it  = reg_wr_i && reg_addr_i == `REG_ITARGET;
  wire wr_per = reg_wr_i && reg_addr_i == `REG_PERIOD;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      option_q    <= `OPTION_RST;
      vtarget_q   <= 16'h0000;
      itarget_q   <= 16'h0000;
      period_q    <= `PERIOD_RST;
      reg_rdata_o <= 16'h0000;
    end else begin
      if (wr_opt) option_q <= reg_wdata_i;
      if (wr_vt)  vtarget_q <= reg_wdata_i;
      if (wr_it)  itarget_q <= reg_wdata_i;
      if (wr_per) period_q <= reg_wdata_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `REG_OPTION:   reg_rdata_o <= option_q;
          `REG_VTARGET:  reg_rdata_o <= vtarget_q;
          `REG_ITARGET:  reg_rdata_o <= itarget_q;
          `REG_PERIOD:   reg_rdata_o <= period_q;
          `REG_STATUS:   reg_rdata_o <= st;
          `REG_SHORTCNT: reg_rdata_o <= {13'h0000, short_cnt_q};
          default:       reg_rdata_o <= 16'h0000;
        endcase
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Switching period with frequency adjust
  // Frequency, not period, moves by the percentage, hence a divide
  // Limitation: slow periods wrap above 16 bits, keep the period below 53000
  wire [31:0] per_x100 = {16'h0000, period_q} * 32'(`PCT_SCALE);
  wire [31:0] per_slow = per_x100 / 32'(`PCT_SCALE - `FADJ_PCT);
  wire [31:0] per_fast = per_x100 / 32'(`PCT_SCALE + `FADJ_PCT);
  wire [15:0] per_eff = !option_q[`OPT_FADJ_EN] ? period_q :
                        option_q[`OPT_FADJ_UP] ? per_fast[15:0] :
                        per_slow[15:0];

  logic [15:0] ramp_q;
  // Period counts whole clocks from the ramp offset
  wire         cyc_end   = ramp_q >= per_eff + `RAMP_OFFSET_RST - 16'h0001;
  wire         cyc_start = cyc_end;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) ramp_q <= `RAMP_OFFSET_RST;
    else if (cyc_end) ramp_q <= `RAMP_OFFSET_RST;
    else ramp_q <= ramp_q + 16'h0001;
  end
  assign ramp_o = ramp_q;

  // ==========================================================
  // Protection latches and timers
  logic          inoc_q, short_q, batov_dis_q, thermal_q, nonsync_q;
  logic [TW-1:0] inoc_cnt_q, batov_cnt_q, bshort_cnt_q;
  logic          hs_short_d1_q, ls_short_d1_q;

  wire adapter_gone = s_q.adapter_detect_low;
  wire batov = s_q.battery_overvoltage && (vtarget_q != 16'h0000);
  wire bshort = s_q.battery_shorted_floor;
  wire hs_ev = s_q.hs_short && !hs_short_d1_q && option_q[`OPT_HS_SHORT_EN];
  wire ls_ev = s_q.ls_short && !ls_short_d1_q;
  wire inoc_run = s_q.input_overcurrent_trip && option_q[`OPT_INOC_EN];

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      inoc_q <= 1'b0;
      short_q <= 1'b0;
      short_cnt_q <= 3'h0;
      batov_dis_q <= 1'b0;
      thermal_q <= 1'b0;
      nonsync_q <= 1'b1;
      inoc_cnt_q <= '0;
      batov_cnt_q <= '0;
      bshort_cnt_q <= '0;
      hs_short_d1_q <= 1'b0;
      ls_short_d1_q <= 1'b0;
    end else begin
      hs_short_d1_q <= s_q.hs_short;
      ls_short_d1_q <= s_q.ls_short;
      inoc_cnt_q <= bump(inoc_cnt_q, inoc_run && !done(inoc_cnt_q, INOC_BLANK_CYC));
      if (adapter_gone) inoc_q <= 1'b0;
      else if (inoc_run && done(inoc_cnt_q, INOC_BLANK_CYC)) inoc_q <= 1'b1;
      batov_cnt_q <= bump(batov_cnt_q, batov && !done(batov_cnt_q, BATOV_QUAL_CYC));
      if (batov && done(batov_cnt_q, BATOV_QUAL_CYC)) batov_dis_q <= 1'b1;
      if (s_q.thermal_hi) thermal_q <= 1'b1;
      else if (s_q.thermal_lo) thermal_q <= 1'b0;
      if (s_q.avg_below_low || bshort) nonsync_q <= 1'b1;
      else if (s_q.avg_above_high) nonsync_q <= 1'b0;
      bshort_cnt_q <= bump(bshort_cnt_q, bshort && !done(bshort_cnt_q, SHORT_RES_CYC));
      if (s_q.supply_undervoltage_lockout || adapter_gone) begin
        short_q <= 1'b0;
        short_cnt_q <= 3'h0;
      end else if ((hs_ev || ls_ev) && !short_q) begin
        if (short_cnt_q == `SHORT_LIMIT - 3'h1) short_q <= 1'b1;
        short_cnt_q <= short_cnt_q + 3'h1;
      end
    end
  end

  // Shorted battery: charge reset between first and second delay
  wire bshort_hold = bshort && done(bshort_cnt_q, SHORT_RST_CYC)
                     && !done(bshort_cnt_q, SHORT_RES_CYC);

  wire run = !option_q[`OPT_INHIBIT] && !inoc_q && !short_q && !batov_dis_q
             && !thermal_q && !bshort_hold && itarget_q != 16'h0000
             && vtarget_q != 16'h0000;

  assign adapter_switch_o       = !inoc_q && !short_q;
  assign reverse_block_switch_o = !inoc_q && !short_q;
  assign battery_switch_o       = short_q;
  assign discharge_sink_o       = batov;

  // ==========================================================
  // Soft-start of the current target
  logic [15:0]   tgt_q;
  logic [TW-1:0] ss_cnt_q;
  wire [15:0] cap = bshort ? `BSHORT_CAP_CODE : itarget_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !run) begin
      tgt_q <= `SS_INIT_CODE;
      ss_cnt_q <= '0;
    end else begin
      ss_cnt_q <= done(ss_cnt_q, SS_STEP_CYC - 1) ? '0 : ss_cnt_q + TW'(1);
      if (tgt_q > cap) tgt_q <= cap;
      else if (done(ss_cnt_q, SS_STEP_CYC - 1) && tgt_q < cap)
        tgt_q <= tgt_q + `SS_STEP_CODE;
    end
  end
  assign current_target_o = tgt_q;

  assign ocp_tier_o = itarget_q <= `OCP_TIER1_MAX ? buck_pkg::OCP_6A :
                      itarget_q <= `OCP_TIER2_MAX ? buck_pkg::OCP_9A :
                      buck_pkg::OCP_12A;
  assign ls_short_high_th_o = option_q[`OPT_LS_HI_TH];
  assign hs_short_en_o = option_q[`OPT_HS_SHORT_EN];

  // ==========================================================
  // Gate sequencing
  typedef enum logic [2:0] {
    G_OFF, G_DEAD_H, G_HIGH, G_DEAD_L, G_LOW
  } gate_type;
  gate_type g_q, g_d;
  logic [3:0] dt_q;
  logic hs_done_q, ls_done_q;

  wire dt_ok = dt_q >= 4'(`DEAD_CYC);
  wire want_h = run && !batov && !hs_done_q && s_q.ramp_above;
  wire refresh = s_q.boot_low;
  wire want_l = run && !batov && !ls_done_q && !cyc_end
                && (refresh || (!nonsync_q && !bshort && !s_q.under_current));

  always_comb begin
    g_d = g_q;
    case (g_q)
      G_OFF:    if (want_h) g_d = G_DEAD_H;
                else if (want_l && hs_done_q) g_d = G_DEAD_L;
      G_DEAD_H: if (!want_h || s_q.peak_oc) g_d = G_OFF;
                else if (dt_ok) g_d = G_HIGH;
      G_HIGH:   if (!want_h || s_q.peak_oc) g_d = G_OFF;
      G_DEAD_L: if (!want_l) g_d = G_OFF;
                else if (dt_ok) g_d = G_LOW;
      G_LOW:    if (!want_l || (refresh && !s_q.boot_low)) g_d = G_OFF;
      default:  g_d = G_OFF;
    endcase
    if (cyc_start && g_q == G_LOW) g_d = G_OFF;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      g_q <= G_OFF;
      dt_q <= 4'h0;
      hs_done_q <= 1'b0;
      ls_done_q <= 1'b0;
    end else begin
      g_q <= g_d;
      dt_q <= (g_d != g_q) ? 4'h0 : dt_q + {3'h0, dt_q != 4'hf};
      if (cyc_start) hs_done_q <= 1'b0;
      else if (s_q.peak_oc || (g_q == G_HIGH && g_d == G_OFF)) hs_done_q <= 1'b1;
      if (cyc_start) ls_done_q <= 1'b0;
      else if (g_q == G_LOW && g_d == G_OFF) ls_done_q <= 1'b1;
    end
  end

  assign high_side_switch_o = g_q == G_HIGH;
  assign low_side_switch_o  = g_q == G_LOW;

  // ==========================================================
  // Status
  assign st = '{rsvd: 5'h00, tier: ocp_tier_o, nonsync: nonsync_q,
                short_latched: short_q, inoc_latched: inoc_q, batov_active: batov,
                batov_disabled: batov_dis_q, bat_short: bshort, thermal_off: thermal_q,
                charging: run, high_side: g_q == G_HIGH};

endmodule // buck_ctrl
`default_nettype wire

// >>> test/buck_ctrl_checker.sv
// Purpose: Port-level checks of buck_ctrl
// Assumes: Two-flop input synchronisers
// Notes:   Attached by the bind at the foot
`timescale 1ns/1ns
`default_nettype none
`include "buck_cfg.svh"
module buck_ctrl_checker (
  input wire logic                   mclk_i,
  input wire logic                   rstn_i,
  input wire logic [3:0]             reg_addr_i,
  input wire logic [15:0]            reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [15:0]            reg_rdata_o,
  input wire buck_pkg::sense_type    sense_i,
  input wire logic                   high_side_switch_o,
  input wire logic                   low_side_switch_o,
  input wire logic                   adapter_switch_o,
  input wire logic                   reverse_block_switch_o,
  input wire logic                   battery_switch_o,
  input wire logic                   discharge_sink_o,
  input wire logic [15:0]            ramp_o,
  input wire logic [15:0]            current_target_o,
  input wire buck_pkg::ocp_tier_type ocp_tier_o,
  input wire logic                   ls_short_high_th_o,
  input wire logic                   hs_short_en_o
);
  wire clr_w = sense_i.supply_undervoltage_lockout | sense_i.adapter_detect_low;
  wire ov_w  = sense_i.battery_overvoltage;
  // ==========
  // Properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  property p_no_overlap; !(high_side_switch_o && low_side_switch_o); endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both gates on");
  property p_dead_hl; $fell(high_side_switch_o) |-> !low_side_switch_o [*4]; endproperty
  a_dead_hl: assert property (p_dead_hl)
    else $error("low side on inside dead time");
  property p_dead_lh; $fell(low_side_switch_o) |-> !high_side_switch_o [*4]; endproperty
  a_dead_lh: assert property (p_dead_lh)
    else $error("high side on inside dead time");
  property p_reset_off;
    disable iff (1'b0) !rstn_i |=> !high_side_switch_o && !low_side_switch_o && !battery_switch_o;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("outputs active in reset");
  property p_sw_pair; adapter_switch_o == reverse_block_switch_o; endproperty
  a_sw_pair: assert property (p_sw_pair)
    else $error("adapter and reverse switch differ");
  property p_batt_latch; battery_switch_o |-> !adapter_switch_o; endproperty
  a_batt_latch: assert property (p_batt_latch)
    else $error("battery and adapter switch both on");
  property p_latch_clear;
    $fell(battery_switch_o) |-> $past(clr_w) || $past(clr_w, 2) || $past(clr_w, 3) || $past(clr_w, 4);
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("short latch cleared without cause");
  property p_sink; discharge_sink_o |-> $past(ov_w) || $past(ov_w, 2) || $past(ov_w, 3); endproperty
  a_sink: assert property (p_sink)
    else $error("sink on without over-voltage");
  property p_ov_inhibit;
    ov_w [*4] |-> !$rose(high_side_switch_o) && !$rose(low_side_switch_o);
  endproperty
  a_ov_inhibit: assert property (p_ov_inhibit)
    else $error("gate turned on during over-voltage");
  property p_peak; sense_i.peak_oc [*6] |-> !high_side_switch_o; endproperty
  a_peak: assert property (p_peak)
    else $error("high side on during peak over-current");
  property p_opt;
    reg_wr_i && reg_addr_i == `REG_OPTION |=> ls_short_high_th_o == $past(reg_wdata_i[7])
      && hs_short_en_o == $past(reg_wdata_i[8]);
  endproperty
  a_opt: assert property (p_opt)
    else $error("short threshold selects wrong");
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
endmodule // buck_ctrl_checker
bind buck_ctrl buck_ctrl_checker u_chk (.mclk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .sense_i, .high_side_switch_o, .low_side_switch_o, .adapter_switch_o,
  .reverse_block_switch_o, .battery_switch_o, .discharge_sink_o, .ramp_o, .current_target_o,
  .ocp_tier_o, .ls_short_high_th_o, .hs_short_en_o);
`default_nettype wire

// >>> test/buck_ctrl_test.sv
// Purpose: Self-checking bench for buck_ctrl
// Assumes: Shortened protection counts
// Notes:   Expectations come from the bench model only
`timescale 1ns/1ns
`default_nettype none
`include "buck_cfg.svh"
module buck_ctrl_test;
  logic                   mclk_i, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0]             reg_addr_i = 4'h0;
  logic [15:0]            reg_wdata_i = 16'h0000, ea = 16'h0080, seed = 16'h0026, v, rdata;
  logic [15:0]            ramp, tgt;
  buck_pkg::status_type   stv;
  // Cool die, average current high
  buck_pkg::sense_type    cond = 15'h0024, sense;
  buck_pkg::ocp_tier_type tier;
  logic                   hs, ls, ac, rb, bs, sink, lsth, hsen, ls_seen = 1'b0;
  int                     failures = 0, comparisons = 0, cyc = 0, n, opt_m, short_m = 0;
  int                     t[3];
  logic [15:0]            tcode[4] = '{16'h0040, 16'h0041, 16'h0060, 16'h0061};
  logic [15:0]            fopt[3] = '{16'h0102, 16'h0302, 16'h0702};
  buck_ctrl #(.INOC_BLANK_CYC(40), .BATOV_QUAL_CYC(40), .SHORT_RST_CYC(30),
    .SHORT_RES_CYC(50), .SS_STEP_CYC(20)) uut (.mclk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata), .sense_i(sense), .high_side_switch_o(hs),
    .low_side_switch_o(ls), .adapter_switch_o(ac), .reverse_block_switch_o(rb),
    .battery_switch_o(bs), .discharge_sink_o(sink), .ramp_o(ramp), .current_target_o(tgt),
    .ocp_tier_o(tier), .ls_short_high_th_o(lsth), .hs_short_en_o(hsen));
  buck_plant plant (.mclk_i, .high_side_switch_i(hs), .low_side_switch_i(ls), .ramp_i(ramp),
    .error_amp_level_i(ea), .cond_i(cond), .sense_o(sense));
  // ==========
  // Helpers
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (ls === 1'b1) ls_seen <= 1'b1;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int tier_m(logic [15:0] c);
    return c <= `OCP_TIER1_MAX ? 0 : (c <= `OCP_TIER2_MAX ? 1 : 2);
  endfunction
  task automatic chk_w(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(string nm, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge mclk_i);
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic hs_rise(output int k);
    logic p;
    k = 0;
    p = 1'b1;
    while (!(hs === 1'b1 && p === 1'b0) && k < 2000) begin
      p = hs;
      @(posedge mclk_i);
      #1 k++;
    end
  endtask
  task automatic end_sim();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    tick(9);
    #1 chk_b("gates_rst", 1'b0, hs | ls);
    chk_b("adapter_rst", 1'b1, ac & rb & !bs);
    chk_w("ramp_rst", `RAMP_OFFSET_RST, ramp);
    chk_w("target_rst", `SS_INIT_CODE, tgt);
    tick(1);
    rstn_i <= 1'b1;
    rd(`REG_OPTION, v);
    chk_w("option_rst", `OPTION_RST, v);
    rd(`REG_PERIOD, v);
    chk_w("period_rst", `PERIOD_RST, v);
    wr(4'h6, 16'hffff);
    rd(4'h6, v);
    chk_w("unmapped", 16'h0000, v);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      opt_m = seed;
      wr(`REG_OPTION, seed);
      rd(`REG_OPTION, v);
      chk_w("option", 16'(opt_m) & 16'h0783, v & 16'h0783);
      chk_b("ls_high_th", opt_m[7], lsth);
      chk_b("hs_short_en", opt_m[8], hsen);
    end
    foreach (tcode[i]) begin
      wr(`REG_ITARGET, tcode[i]);
      tick(1);
      #1 chk_w("ocp_tier", 16'(tier_m(tcode[i])), {14'h0000, tier});
    end
    wr(`REG_VTARGET, 16'h3000);
    wr(`REG_ITARGET, 16'h0020);
    foreach (fopt[i]) begin
      wr(`REG_OPTION, fopt[i]);
      repeat (3) hs_rise(t[i]);
    end
    chk_b("switching", 1'b1, t[0] < 2000 && ls_seen);
    chk_b("freq_down", 1'b1, (t[1] * (100 - `FADJ_PCT) - t[0] * 100) / t[0] == 0);
    chk_b("freq_up", 1'b1, (t[2] * (100 + `FADJ_PCT) - t[0] * 100) / t[0] == 0);
    chk_w("ss_target", 16'h0020, tgt);
    wr(`REG_OPTION, fopt[0]);
    cond.peak_oc <= 1'b1;
    tick(8);
    cond.peak_oc <= 1'b0;
    #1 chk_b("hs_cut", 1'b0, hs);
    tick(20);
    #1 chk_b("hs_rest", 1'b0, hs);
    hs_rise(n);
    chk_b("hs_resume", 1'b1, n < 2000);
    for (int i = 0; i < 7; i++) begin
      tick(1);
      if (i % 2) cond.hs_short <= 1'b1;
      else cond.ls_short <= 1'b1;
      short_m++;
      tick(3);
      cond.ls_short <= 1'b0;
      cond.hs_short <= 1'b0;
      tick(4);
      #1 chk_b("battery_sw", short_m >= 7, bs);
      chk_w("ss_restart", short_m >= 7 ? `SS_INIT_CODE : 16'h0020, tgt);
      chk_b("adapter_sw", short_m < 7, ac);
    end
    for (int i = 1; i >= 0; i--) begin
      wr(`REG_OPTION, i ? 16'h0102 : 16'h0100);
      tick(1);
      cond.adapter_detect_low <= 1'b1;
      tick(5);
      cond.adapter_detect_low <= 1'b0;
      short_m = 0;
      tick(5);
      #1 chk_b("adapter_clear", 1'b1, ac & !bs);
      tick(1);
      cond.input_overcurrent_trip <= 1'b1;
      tick(20);
      #1 chk_b("adapter_blank", 1'b1, ac);
      tick(40);
      #1 chk_b("adapter_inoc", !i, ac);
      tick(1);
      cond.input_overcurrent_trip <= 1'b0;
    end
    wr(`REG_VTARGET, 16'h0000);
    cond.battery_overvoltage <= 1'b1;
    tick(6);
    #1 chk_b("sink_zero_target", 1'b0, sink);
    wr(`REG_VTARGET, 16'h3000);
    tick(1);
    #1 chk_b("sink_on", 1'b1, sink);
    tick(1);
    cond.battery_overvoltage <= 1'b0;
    tick(5);
    #1 chk_b("sink_off", 1'b0, sink);
    tick(1);
    cond.battery_overvoltage <= 1'b1;
    tick(50);
    cond.battery_overvoltage <= 1'b0;
    #1 chk_b("ov_gates", 1'b0, hs | ls);
    tick(5);
    rd(`REG_STATUS, v);
    stv = v;
    chk_b("ov_disabled", 1'b1, stv.batov_disabled);
    chk_b("ov_no_charge", 1'b0, stv.charging);
    end_sim();
  end
endmodule // buck_ctrl_test
`default_nettype wire

// >>> test/buck_plant.sv
// Purpose: Power stage and comparators seen by buck_ctrl
// Assumes: Inductor and bootstrap as coarse counters
// Notes:   Other comparator levels pass through from the bench
`timescale 1ns/1ns
`default_nettype none
module buck_plant (
  input  wire logic                mclk_i,
  input  wire logic                high_side_switch_i,
  input  wire logic                low_side_switch_i,
  input  wire logic [15:0]         ramp_i,
  input  wire logic [15:0]         error_amp_level_i,
  input  wire buck_pkg::sense_type cond_i,
  output var  buck_pkg::sense_type sense_o
);
  int coil_q = 0;
  int boot_q = 0;
  initial sense_o = '0;
  always @(posedge mclk_i) begin
    if (high_side_switch_i) coil_q <= coil_q + 2;
    else if (coil_q > 0) coil_q <= coil_q - 1;
    // Bootstrap sags unless the low side conducts now and then
    boot_q <= low_side_switch_i ? 0 : boot_q + 1;
    sense_o <= cond_i;
    sense_o.ramp_above <= error_amp_level_i > ramp_i;
    sense_o.under_current <= coil_q < 1;
    sense_o.boot_low <= boot_q > 600;
  end
endmodule // buck_plant
`default_nettype wire
